// [core/pwrseq_pkg.sv]
// Package with constants and types for the regulator power sequencer.
package pwrseq_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int DEGLITCH_US = 1000;
    localparam int DEGLITCH_CYC = (CLK_HZ / 1_000_000) * DEGLITCH_US;
    localparam int DLY_UNIT_US = 500;
    localparam int DLY_UNIT_CYC = (CLK_HZ / 1_000_000) * DLY_UNIT_US;
    localparam int PFM_ENTRY_CYCLES = 32;
    localparam int NUM_RAILS = 4;

    // ****************************************************************
    // Delay selection codes: 1, 1.5, 2, 3, 6, 11 ms
    // ****************************************************************
    localparam logic [2:0] DSEL_1MS = 3'h0;
    localparam logic [2:0] DSEL_1P5MS = 3'h1;
    localparam logic [2:0] DSEL_2MS = 3'h2;
    localparam logic [2:0] DSEL_3MS = 3'h3;
    localparam logic [2:0] DSEL_6MS = 3'h4;
    localparam logic [2:0] DSEL_11MS = 3'h5;
    localparam logic [11:0] DSEL_DEFAULT = {DSEL_6MS, DSEL_3MS, DSEL_2MS, DSEL_1P5MS};

    // Delay in half-millisecond units for a selection code.
    function automatic logic [4:0] dsel_units(input logic [2:0] sel);
        logic [4:0] u;
        u = 5'h02;
        unique case (sel)
            DSEL_1MS: u = 5'h02;
            DSEL_1P5MS: u = 5'h03;
            DSEL_2MS: u = 5'h04;
            DSEL_3MS: u = 5'h06;
            DSEL_6MS: u = 5'h0c;
            DSEL_11MS: u = 5'h16;
            default: u = 5'h02;
        endcase
        return u;
    endfunction : dsel_units

    // ****************************************************************
    // Soft start current limit steps
    // ****************************************************************
    localparam logic [1:0] ILIM_213MA = 2'h0;
    localparam logic [1:0] ILIM_425MA = 2'h1;
    localparam logic [1:0] ILIM_850MA = 2'h2;
    localparam logic [1:0] ILIM_1700MA = 2'h3;
    localparam int SS_STEP_CYC = 256;

    // Per-rail enable bundle in order buck one, buck two, linear one, linear two.
    typedef struct packed {
        logic linear_reg_two;
        logic linear_reg_one;
        logic buck_two;
        logic buck_one;
    } rail_vec_t;

    // Comparator and detector inputs of one buck.
    typedef struct packed {
        logic below_high;
        logic below_low;
        logic below_low2;
        logic pfm_peak_current_limit;
        logic zero_current;
        logic light_load;
        logic low_headroom;
    } buck_sense_t;

    // Switch drive of one buck.
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic pwm_mode;
        logic bias_on;
        logic [1:0] current_limit;
    } buck_drive_t;

endpackage : pwrseq_pkg

// [core/trig_deglitch.sv]
// Synchroniser and deglitch filter for the sequence trigger input.
`timescale 1ns/1ps
module trig_deglitch
    import pwrseq_pkg::*;
#(
    parameter int HOLD_CYC = DEGLITCH_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_raw,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic sync1_reg, sync2_reg, level_reg;
    logic [$clog2(HOLD_CYC+1)-1:0] cnt_reg;
    wire differ = sync2_reg != level_reg;
    wire done = cnt_reg == ($bits(cnt_reg))'(HOLD_CYC - 1);

    // Only a change held stable for the full interval updates the level.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            level_reg <= 1'b0;
            cnt_reg <= '0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            sync1_reg <= i_raw;
            sync2_reg <= sync1_reg;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (!differ) begin
                cnt_reg <= '0;
            end else if (done) begin
                cnt_reg <= '0;
                level_reg <= sync2_reg;
                o_rise <= sync2_reg;
                o_fall <= !sync2_reg;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
    assign o_level = level_reg;
endmodule : trig_deglitch

// [core/buck_ctrl.sv]
// Modulation, PFM switch cycle, shutdown discharge and soft start of one buck.
`timescale 1ns/1ps
module buck_ctrl
    import pwrseq_pkg::*;
#(
    parameter int ENTRY_CYC = PFM_ENTRY_CYCLES,
    parameter int STEP_CYC = SS_STEP_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_vin_ok,
    input wire logic i_force_pwm,
    input wire logic i_pwm_tick,
    input wire buck_sense_t i_sense,
    output buck_drive_t o_drive
);
    typedef enum {ST_OFF, ST_PWM, ST_PFM_HIGH, ST_PFM_LOW, ST_PFM_BRAKE, ST_PFM_SLEEP} st_t;
    st_t st_reg, st_next;
    logic en_d_reg, ss_active_reg;
    logic [1:0] ilim_reg;
    logic [$clog2(STEP_CYC)-1:0] step_reg;
    logic [$clog2(ENTRY_CYC+1)-1:0] light_reg;
    logic pwm_ph_reg;
    logic s_below_high, s_below_low, s_below_low2, s_peak, s_zero, s_light, s_head;

    assign s_below_high = i_sense.below_high;
    assign s_below_low = i_sense.below_low;
    assign s_below_low2 = i_sense.below_low2;
    assign s_peak = i_sense.pfm_peak_current_limit;
    assign s_zero = i_sense.zero_current;
    assign s_light = i_sense.light_load;
    assign s_head = i_sense.low_headroom;

    wire in_pfm = st_reg inside {ST_PFM_HIGH, ST_PFM_LOW, ST_PFM_BRAKE, ST_PFM_SLEEP};
    wire pfm_entry = light_reg >= ($bits(light_reg))'(ENTRY_CYC);

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_OFF: if (i_enable) st_next = ST_PWM;
            ST_PWM: if (!i_force_pwm && pfm_entry) st_next = ST_PFM_SLEEP;
            ST_PFM_HIGH: if (!s_below_high || s_peak) st_next = ST_PFM_LOW;
            ST_PFM_LOW: if (s_zero) st_next = s_below_high ? ST_PFM_HIGH : ST_PFM_SLEEP;
            ST_PFM_BRAKE: if (s_zero) st_next = ST_PFM_SLEEP;
            ST_PFM_SLEEP: if (s_below_low) st_next = ST_PFM_HIGH;
        endcase
        if (in_pfm && (s_below_low2 || i_force_pwm)) st_next = ST_PWM;
        if (st_reg == ST_PFM_HIGH && !s_below_high && !s_peak) st_next = ST_PFM_BRAKE;
        if (in_pfm && (s_below_low2 || i_force_pwm)) st_next = ST_PWM;
        if (!i_enable) st_next = ST_OFF;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= ST_OFF;
            en_d_reg <= 1'b0;
            ss_active_reg <= 1'b0;
            ilim_reg <= ILIM_1700MA;
            step_reg <= '0;
            light_reg <= '0;
            pwm_ph_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            en_d_reg <= i_enable;
            pwm_ph_reg <= i_pwm_tick ? !pwm_ph_reg : pwm_ph_reg;
            if (st_reg != ST_PWM || !s_light) begin
                light_reg <= '0;
            end else if (i_pwm_tick && !pfm_entry) begin
                light_reg <= light_reg + 1'b1;
            end
            if (i_enable && !en_d_reg && i_vin_ok) begin
                ss_active_reg <= 1'b1;
                ilim_reg <= ILIM_213MA;
                step_reg <= '0;
            end else if (ss_active_reg) begin
                step_reg <= step_reg + 1'b1;
                if (step_reg == ($bits(step_reg))'(STEP_CYC - 1)) begin
                    ilim_reg <= ilim_reg + 1'b1;
                    ss_active_reg <= ilim_reg != ILIM_850MA;
                end
            end
            if (!i_enable) ss_active_reg <= 1'b0;
        end
    end

    wire pwm_hs = s_head ? 1'b1 : pwm_ph_reg;
    assign o_drive.high_side_on = (st_reg == ST_PWM && pwm_hs) || st_reg == ST_PFM_HIGH;
    assign o_drive.low_side_on = st_reg == ST_OFF
        || (st_reg == ST_PWM && !pwm_hs)
        || st_reg == ST_PFM_LOW || st_reg == ST_PFM_BRAKE;
    assign o_drive.pwm_mode = st_reg == ST_PWM;
    assign o_drive.bias_on = st_reg != ST_OFF;
    assign o_drive.current_limit = ilim_reg;
endmodule : buck_ctrl

// [core/regulator_power_sequencer.sv]
// Top level of the four-rail power sequencer and buck control logic.
`timescale 1ns/1ps

// Contract
// - Trigger rising starts power-on, falling shutdown.
// - Trigger edges recognised only after deglitch time.
// - Default on delays 1.5, 2, 3, 6 ms.
// - Each rail delay selectable from six values.
// - Rail on = enable bit AND (pin OR trigger); the code ignores the pins while the deglitched trigger is high.
// - Enable bits reset to on.
// - Bucks enabled by sequence; voltages revert after.
// - Auto PWM/PFM unless force bit set.
// - Below low2 threshold in PFM returns PWM.
// - PFM high side on until threshold or peak.
// - Low side on until zero current detected.
// - At threshold brake, then sleep until low.
// - Shutdown: switches and bias off, low side discharges.
// - Soft start only on enable rise, supply good.
// - Current limit steps 213, 425, 850, 1700 mA.
// - Low headroom allows full duty cycle.
// - PFM entry after 32 light-load switching cycles.
// - Default off delays 1.5, 2, 3, 6 ms.
module regulator_power_sequencer
    import pwrseq_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
    parameter int UNIT_CYCLES = DLY_UNIT_CYC,
    parameter int BUCK_ENTRY_CYCLES = PFM_ENTRY_CYCLES,
    parameter int SOFT_STEP_CYCLES = SS_STEP_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic i_SEQ_TRIGGER,
    input wire rail_vec_t i_RAIL_PIN_ENABLE,
    input wire rail_vec_t i_REG_ENABLE_WR_DATA,
    input wire logic i_REG_ENABLE_WR,
    input wire logic [11:0] i_DELAY_SEL,
    input wire logic i_DELAY_SEL_WR,
    input wire logic [1:0] i_FORCE_PWM,
    input wire logic i_VIN_OK,
    input wire logic i_PWM_TICK,
    input wire buck_sense_t i_BUCK_ONE_SENSE,
    input wire buck_sense_t i_BUCK_TWO_SENSE,
    output rail_vec_t o_RAIL_ON,
    output rail_vec_t o_REG_ENABLE,
    output logic o_SEQ_ACTIVE,
    output logic o_SEQ_DONE,
    output logic o_VOUT_REVERT,
    output buck_drive_t o_BUCK_ONE_DRIVE,
    output buck_drive_t o_BUCK_TWO_DRIVE
);
    // ****************************************************************
    // Input synchronisers for pins
    // ****************************************************************
    rail_vec_t pin_s1_reg, pin_s2_reg;
    logic vin_s1_reg, vin_s2_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            vin_s1_reg <= 1'b0;
            vin_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= i_RAIL_PIN_ENABLE;
            pin_s2_reg <= pin_s1_reg;
            vin_s1_reg <= i_VIN_OK;
            vin_s2_reg <= vin_s1_reg;
        end
    end

    // ****************************************************************
    // Trigger deglitch
    // ****************************************************************
    logic trig_level, trig_rise, trig_fall;

    trig_deglitch #(
        .HOLD_CYC(DEGLITCH_CYCLES)
    ) u_deglitch (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_raw(i_SEQ_TRIGGER),
        .o_level(trig_level),
        .o_rise(trig_rise),
        .o_fall(trig_fall)
    );

    // ****************************************************************
    // Configuration bits
    // ****************************************************************
    rail_vec_t reg_en_reg;
    logic [11:0] dsel_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            reg_en_reg <= '1;
            dsel_reg <= DSEL_DEFAULT;
        end else begin
            if (i_REG_ENABLE_WR) reg_en_reg <= i_REG_ENABLE_WR_DATA;
            if (i_DELAY_SEL_WR) dsel_reg <= i_DELAY_SEL;
        end
    end
    assign o_REG_ENABLE = reg_en_reg;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum {SQ_IDLE, SQ_UP, SQ_DOWN} sq_t;
    sq_t sq_reg, sq_next;
    logic [$clog2(UNIT_CYCLES)-1:0] pre_reg;
    logic [4:0] units_reg;
    rail_vec_t seq_on_reg;
    logic revert_reg;
    logic [4:0] rail_units [NUM_RAILS];
    logic [NUM_RAILS-1:0] rail_hit;

    // Each rail switches when the shared half-millisecond count reaches its own delay.
    for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
        assign rail_units[g] = dsel_units(dsel_reg[3*g +: 3]);
        assign rail_hit[g] = units_reg >= rail_units[g];
    end

    wire unit_tick = pre_reg == ($bits(pre_reg))'(UNIT_CYCLES - 1);
    wire all_hit = &rail_hit;

    always_comb begin
        sq_next = sq_reg;
        unique case (sq_reg)
            SQ_IDLE: sq_next = SQ_IDLE;
            SQ_UP: if (all_hit) sq_next = SQ_IDLE;
            SQ_DOWN: if (all_hit) sq_next = SQ_IDLE;
        endcase
        if (trig_rise) sq_next = SQ_UP;
        if (trig_fall) sq_next = SQ_DOWN;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sq_reg <= SQ_IDLE;
            pre_reg <= '0;
            units_reg <= '0;
            seq_on_reg <= '0;
            revert_reg <= 1'b0;
        end else begin
            sq_reg <= sq_next;
            revert_reg <= 1'b0;
            if (trig_rise || trig_fall) begin
                pre_reg <= '0;
                units_reg <= '0;
            end else if (sq_reg != SQ_IDLE) begin
                pre_reg <= unit_tick ? '0 : pre_reg + 1'b1;
                if (unit_tick && !all_hit) units_reg <= units_reg + 1'b1;
                if (sq_reg == SQ_UP) begin
                    seq_on_reg <= seq_on_reg | rail_hit;
                    revert_reg <= all_hit;
                end else begin
                    seq_on_reg <= seq_on_reg & ~rail_hit;
                end
            end
        end
    end

    assign o_SEQ_ACTIVE = sq_reg != SQ_IDLE;
    assign o_SEQ_DONE = sq_reg == SQ_IDLE && seq_on_reg == '1;
    assign o_VOUT_REVERT = revert_reg;

    // ****************************************************************
    // Rail enable equation
    // ****************************************************************
    // While the trigger is high pin toggles are ignored; the timed state also holds the rails
    // through the cycle in which a falling trigger is seen, so shutdown starts without a dropout.
    rail_vec_t gate_vec;
    assign gate_vec = seq_on_reg | (trig_level ? '0 : pin_s2_reg);
    assign o_RAIL_ON = reg_en_reg & gate_vec;

    // ****************************************************************
    // Buck controllers
    // ****************************************************************
    buck_ctrl #(
        .ENTRY_CYC(BUCK_ENTRY_CYCLES),
        .STEP_CYC(SOFT_STEP_CYCLES)
    ) u_buck_one (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_enable(o_RAIL_ON.buck_one),
        .i_vin_ok(vin_s2_reg),
        .i_force_pwm(i_FORCE_PWM[0]),
        .i_pwm_tick(i_PWM_TICK),
        .i_sense(i_BUCK_ONE_SENSE),
        .o_drive(o_BUCK_ONE_DRIVE)
    );

    buck_ctrl #(
        .ENTRY_CYC(BUCK_ENTRY_CYCLES),
        .STEP_CYC(SOFT_STEP_CYCLES)
    ) u_buck_two (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_enable(o_RAIL_ON.buck_two),
        .i_vin_ok(vin_s2_reg),
        .i_force_pwm(i_FORCE_PWM[1]),
        .i_pwm_tick(i_PWM_TICK),
        .i_sense(i_BUCK_TWO_SENSE),
        .o_drive(o_BUCK_TWO_DRIVE)
    );

endmodule : regulator_power_sequencer

// [bench/pwrseq_assertions.sv]
// Port-level checker for the regulator power sequencer.
`timescale 1ns/1ps
module pwrseq_assertions
    import pwrseq_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic i_SEQ_TRIGGER,
    input wire rail_vec_t i_REG_ENABLE_WR_DATA,
    input wire logic i_REG_ENABLE_WR,
    input wire logic [1:0] i_FORCE_PWM,
    input wire buck_sense_t i_BUCK_ONE_SENSE,
    input wire rail_vec_t o_RAIL_ON,
    input wire rail_vec_t o_REG_ENABLE,
    input wire logic o_SEQ_ACTIVE,
    input wire buck_drive_t o_BUCK_ONE_DRIVE
);
    logic [15:0] calm_reg;
    logic trig_last_reg;
    logic on_b1;
    logic pfm_b1;
    assign on_b1 = o_BUCK_ONE_DRIVE.bias_on;
    assign pfm_b1 = on_b1 && !o_BUCK_ONE_DRIVE.pwm_mode;

    // Counts cycles since the trigger pin last moved.
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            calm_reg <= 16'h0000;
            trig_last_reg <= 1'b0;
        end else begin
            trig_last_reg <= i_SEQ_TRIGGER;
            calm_reg <= (i_SEQ_TRIGGER != trig_last_reg) ? 16'h0000 :
                        calm_reg + {15'h0000, ~&calm_reg};
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);

    a_rail_needs_bit: assert property ((o_RAIL_ON & ~o_REG_ENABLE) == 4'h0)
        else $error("Rail on while its enable bit is clear.");
    a_bit_write: assert property (i_REG_ENABLE_WR |=> o_REG_ENABLE == $past(i_REG_ENABLE_WR_DATA))
        else $error("Enable bits did not take the written value.");
    a_bits_hold: assert property (!i_REG_ENABLE_WR |=> $stable(o_REG_ENABLE))
        else $error("Enable bits changed without a write.");
    a_trig_deglitch: assert property ($rose(o_SEQ_ACTIVE) |-> calm_reg >= DEGLITCH_CYCLES - 2)
        else $error("Sequence started on an unsettled trigger.");
    a_off_discharge: assert property ((!o_RAIL_ON.buck_one) [*3] |-> o_BUCK_ONE_DRIVE.low_side_on && !o_BUCK_ONE_DRIVE.high_side_on && !on_b1)
        else $error("Disabled buck not discharging.");
    a_force_stays: assert property (i_FORCE_PWM[0] && o_BUCK_ONE_DRIVE.pwm_mode |=> o_BUCK_ONE_DRIVE.pwm_mode || !on_b1)
        else $error("Forced buck left fixed frequency mode.");
    a_low2_exit: assert property (pfm_b1 && i_BUCK_ONE_SENSE.below_low2 |-> ##[1:3] !pfm_b1)
        else $error("Buck stayed in pulse mode below the lowest threshold.");
    a_pfm_high_stop: assert property ((pfm_b1 && !i_BUCK_ONE_SENSE.below_high) [*3] |-> !o_BUCK_ONE_DRIVE.high_side_on)
        else $error("High side on above the upper threshold.");
    a_limit_steps: assert property ($changed(o_BUCK_ONE_DRIVE.current_limit) |-> o_BUCK_ONE_DRIVE.current_limit == $past(o_BUCK_ONE_DRIVE.current_limit) + 2'h1 || o_BUCK_ONE_DRIVE.current_limit == ILIM_213MA)
        else $error("Current limit skipped a step.");
    a_full_duty: assert property (o_BUCK_ONE_DRIVE.pwm_mode && i_BUCK_ONE_SENSE.low_headroom
        |-> o_BUCK_ONE_DRIVE.high_side_on)
        else $error("High side switched off with low headroom.");

    c_seq: cover property ($rose(o_SEQ_ACTIVE));
    c_pfm: cover property ($fell(o_BUCK_ONE_DRIVE.pwm_mode) && on_b1);
    c_high: cover property (pfm_b1 && $rose(o_BUCK_ONE_DRIVE.high_side_on));
endmodule : pwrseq_assertions

bind regulator_power_sequencer pwrseq_assertions #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) chk (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .i_SEQ_TRIGGER(i_SEQ_TRIGGER),
    .i_REG_ENABLE_WR_DATA(i_REG_ENABLE_WR_DATA), .i_REG_ENABLE_WR(i_REG_ENABLE_WR),
    .i_FORCE_PWM(i_FORCE_PWM), .i_BUCK_ONE_SENSE(i_BUCK_ONE_SENSE), .o_RAIL_ON(o_RAIL_ON),
    .o_REG_ENABLE(o_REG_ENABLE), .o_SEQ_ACTIVE(o_SEQ_ACTIVE),
    .o_BUCK_ONE_DRIVE(o_BUCK_ONE_DRIVE));

// [bench/host_model.sv]
// Behavioural host driving the trigger, pin enables and configuration writes.
`timescale 1ns/1ps
module host_model
    import pwrseq_pkg::*;
(
    input wire logic i_clk,
    output logic o_trigger,
    output rail_vec_t o_pins,
    output rail_vec_t o_en_data,
    output logic o_en_wr,
    output logic [11:0] o_dly,
    output logic o_dly_wr
);
    // Pin enables start low so nothing powers up ahead of the trigger.
    initial begin
        o_trigger = 1'b0;
        o_pins = 4'h0;
        o_en_data = 4'hf;
        o_en_wr = 1'b0;
        o_dly = DSEL_DEFAULT;
        o_dly_wr = 1'b0;
    end

    // Data is scrambled once the strobe drops, since nothing holds it.
    task automatic configure(input rail_vec_t en, input logic [11:0] dly);
        @(negedge i_clk);
        o_en_data = en;
        o_dly = dly;
        o_en_wr = 1'b1;
        o_dly_wr = 1'b1;
        @(negedge i_clk);
        o_en_wr = 1'b0;
        o_dly_wr = 1'b0;
        o_en_data = ~en;
        o_dly = ~dly;
    endtask : configure

    task automatic set_trigger(input logic lvl);
        @(negedge i_clk);
        o_trigger = lvl;
    endtask : set_trigger

    task automatic set_pins(input rail_vec_t p);
        @(negedge i_clk);
        o_pins = p;
    endtask : set_pins

    task automatic glitch(input int n);
        @(negedge i_clk);
        o_trigger = ~o_trigger;
        repeat (n) @(negedge i_clk);
        o_trigger = ~o_trigger;
    endtask : glitch
endmodule : host_model

// [bench/test_regulator_power_sequencer.sv]
// Self-checking bench for the regulator power sequencer.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED %0t %s", $time, msg); end end
module test_regulator_power_sequencer;
    import pwrseq_pkg::*;
    localparam int DG = 8;
    localparam int UN = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic trig, en_wr, dly_wr, active, done, revert;
    logic vin_ok = 1'b1;
    logic tick = 1'b0;
    logic force_one = 1'b0;
    logic force_two = 1'b0;
    logic [15:0] rnd = 16'h0021;
    logic [11:0] dly, d;
    logic [11:0] ss;
    logic [1:0] last_cl;
    logic [15:0] lfsr = 16'h0021;
    rail_vec_t pins, en_data, rail_on, reg_en, en, p;
    buck_sense_t sense = '0;
    buck_sense_t sense_two = '0;
    buck_drive_t drv, drv_two;
    int bad_count = 0;
    int checked = 0;
    int reverts = 0;
    int t_at[4];

    always #25 clk = ~clk;
    always @(negedge clk) tick <= ~tick;
    always @(posedge clk) if (revert === 1'b1) reverts++;

    host_model host (.i_clk(clk), .o_trigger(trig), .o_pins(pins), .o_en_data(en_data),
        .o_en_wr(en_wr), .o_dly(dly), .o_dly_wr(dly_wr));
    regulator_power_sequencer #(.DEGLITCH_CYCLES(DG), .UNIT_CYCLES(UN),
        .BUCK_ENTRY_CYCLES(32), .SOFT_STEP_CYCLES(4)) uut (
        .I_CLK_SYS(clk), .I_ARST_N(arst_n), .i_SEQ_TRIGGER(trig), .i_RAIL_PIN_ENABLE(pins),
        .i_REG_ENABLE_WR_DATA(en_data), .i_REG_ENABLE_WR(en_wr), .i_DELAY_SEL(dly),
        .i_DELAY_SEL_WR(dly_wr), .i_FORCE_PWM({force_two, force_one}), .i_VIN_OK(vin_ok),
        .i_PWM_TICK(tick), .i_BUCK_ONE_SENSE(sense), .i_BUCK_TWO_SENSE(sense_two),
        .o_RAIL_ON(rail_on), .o_REG_ENABLE(reg_en), .o_SEQ_ACTIVE(active),
        .o_SEQ_DONE(done), .o_VOUT_REVERT(revert), .o_BUCK_ONE_DRIVE(drv),
        .o_BUCK_TWO_DRIVE(drv_two));

    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step

    // Buck two sees random comparators and a random force bit for the whole run.
    always @(negedge clk) begin
        rnd <= step(rnd);
        force_two <= rnd[0];
        sense_two <= buck_sense_t'(rnd[9:3]);
    end

    // Half-millisecond units expected for a delay code.
    function automatic int units(input logic [2:0] c);
        case (c)
            3'h1: return 3;
            3'h2: return 4;
            3'h3: return 6;
            3'h4: return 12;
            3'h5: return 22;
            default: return 2;
        endcase
    endfunction : units

    task automatic watch(input logic lvl, input logic [11:0] c, input string nm);
        for (int r = 0; r < 4; r++) t_at[r] = -1;
        for (int n = 0; n < 130; n++) begin
            @(negedge clk);
            for (int r = 0; r < 4; r++) if (t_at[r] < 0 && rail_on[r] === lvl) t_at[r] = n;
        end
        for (int r = 1; r < 4; r++)
            `CHK(t_at[r] - t_at[0], (units(c[3*r+:3]) - units(c[2:0])) * UN, nm)
        `CHK(t_at[0] >= DG + units(c[2:0]) * UN, 1'b1, nm)
        `CHK(t_at[0] <= DG + 4 + units(c[2:0]) * UN, 1'b1, nm)
        $display("test %s done", nm);
    endtask : watch

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #400_000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        settle(8);
        arst_n = 1'b1;
        settle(1);
        `CHK(reg_en, 4'hf, "enable bits after reset")
        `CHK(rail_on, 4'h0, "rails after reset")
        host.glitch(DG - 3);
        settle(30);
        `CHK({active, rail_on}, 5'h00, "short trigger pulse")
        host.set_trigger(1'b1);
        watch(1'b1, DSEL_DEFAULT, "default on");
        `CHK({done, reverts}, {1'b1, 32'sd1}, "sequence completion")
        host.set_pins(4'ha);
        settle(6);
        `CHK(rail_on, 4'hf, "pins ignored with trigger high")
        `CHK(drv_two.bias_on, 1'b1, "buck two on in sequence")
        host.set_pins(4'h0);
        host.set_trigger(1'b0);
        watch(1'b0, DSEL_DEFAULT, "default off");
        for (int k = 0; k < 3; k++) begin
            lfsr = step(step(lfsr));
            for (int r = 0; r < 4; r++) d[3*r+:3] = 3'(lfsr[4*r+:4] % 6);
            if (k == 0) d = {DSEL_11MS, DSEL_1MS, DSEL_6MS, DSEL_1MS};
            host.configure(4'hf, d);
            host.set_trigger(1'b1);
            watch(1'b1, d, "programmed on");
            host.set_trigger(1'b0);
            watch(1'b0, d, "programmed off");
        end
        for (int k = 0; k < 6; k++) begin
            lfsr = step(lfsr);
            en = lfsr[3:0];
            p = lfsr[7:4];
            host.configure(en, DSEL_DEFAULT);
            host.set_pins(p);
            settle(4);
            `CHK(rail_on, en & p, "pin and enable bit")
        end
        host.configure(4'hf, DSEL_DEFAULT);
        host.set_pins(4'h0);
        settle(6);
        ss = 12'h000;
        last_cl = drv.current_limit;
        host.set_pins(4'h1);
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            if (drv.current_limit !== last_cl) ss = {ss[9:0], drv.current_limit};
            last_cl = drv.current_limit;
        end
        `CHK(ss, 12'h01b, "soft start steps")
        force_one = 1'b1;
        sense.light_load = 1'b1;
        settle(90);
        `CHK(drv.pwm_mode, 1'b1, "forced fixed frequency")
        sense.light_load = 1'b0;
        settle(2);
        force_one = 1'b0;
        sense.light_load = 1'b1;
        settle(50);
        `CHK(drv.pwm_mode, 1'b1, "too few light ticks")
        settle(40);
        `CHK(drv.pwm_mode, 1'b0, "pulse mode entry")
        sense.below_high = 1'b1;
        sense.below_low = 1'b1;
        settle(3);
        `CHK(drv.high_side_on, 1'b1, "pulse charge")
        sense.pfm_peak_current_limit = 1'b1;
        settle(3);
        `CHK({drv.high_side_on, drv.low_side_on}, 2'h1, "peak reached")
        sense.zero_current = 1'b1;
        sense.below_high = 1'b0;
        sense.below_low = 1'b0;
        settle(4);
        `CHK({drv.high_side_on, drv.low_side_on}, 2'h0, "sleep")
        sense.below_low2 = 1'b1;
        settle(4);
        `CHK(drv.pwm_mode, 1'b1, "load step exit")
        sense.low_headroom = 1'b1;
        repeat (2) begin
            settle(2);
            `CHK(drv.high_side_on, 1'b1, "full duty")
        end
        sense = '0;
        host.set_pins(4'h0);
        settle(6);
        `CHK({drv.low_side_on, drv.bias_on, drv.high_side_on}, 3'h4, "discharge")
        `CHK({drv_two.low_side_on, drv_two.bias_on, drv_two.high_side_on}, 3'h4, "two off")
        vin_ok = 1'b0;
        host.set_pins(4'h1);
        settle(6);
        `CHK(drv.current_limit, ILIM_1700MA, "no soft start on low supply")
        $display("test buck done");
        report_and_stop();
    end
endmodule : test_regulator_power_sequencer
